/* File: core/mode_seq_pkg.sv */
package mode_seq_pkg;
  // all intervals run from the slow timekeeping tick, not from the 100 MHz clock
  localparam int unsigned TICK_HZ = 1;
  localparam int unsigned SEC_PER_H = 3600;
  localparam int unsigned CMD_IDLE_S = 300;
  localparam int unsigned WARN_S = 240;
  localparam int unsigned RESUME_S = 300;
  localparam int unsigned RECHARGE_S = 4;
  localparam int unsigned SLEEP_H = 9;
  localparam int unsigned CMD_IDLE_TICKS = CMD_IDLE_S * TICK_HZ;
  localparam int unsigned WARN_TICKS = WARN_S * TICK_HZ;
  localparam int unsigned RESUME_TICKS = RESUME_S * TICK_HZ;
  localparam int unsigned RECHARGE_TICKS = RECHARGE_S * TICK_HZ;
  localparam int unsigned SLEEP_TICKS_DEF = SLEEP_H * SEC_PER_H * TICK_HZ;
  localparam int unsigned TMR_W = 16;
  localparam int unsigned PING_CNT_W = 8;
  localparam logic [1:0] WAKE_BREAK = 2'h0;
  localparam logic [1:0] WAKE_START = 2'h1;
  localparam logic [1:0] WAKE_TIMER = 2'h2;
  localparam logic [1:0] WAKE_WDOG = 2'h3;

  typedef enum logic [6:0] {
    S_SLEEP = 7'h01,
    S_PROMPT_CMD = 7'h02,
    S_PROMPT_PING = 7'h04,
    S_RECHARGE = 7'h08,
    S_WAIT_TF = 7'h10,
    S_WAIT_ALARM = 7'h20,
    S_PINGING = 7'h40
  } mode_state_t;

  typedef enum logic [5:0] {
    Q_IDLE = 6'h01,
    Q_TX = 6'h02,
    Q_RX = 6'h04,
    Q_TEST = 6'h08,
    Q_SENSE = 6'h10,
    Q_HOLD = 6'h20
  } seq_state_t;
endpackage : mode_seq_pkg

/* File: core/tick_timer.sv */
`timescale 1ns/10ps
module tick_timer
  import mode_seq_pkg::*;
#(
  parameter int unsigned W = TMR_W,
  parameter int unsigned LIMIT = 1
)(
  input wire logic clock, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic clear, // hold count at zero
  input wire logic tick, // slow timekeeping tick
  output logic [W-1:0] count, // ticks since clear, saturating
  output logic done // count reached LIMIT
);
  logic [W-1:0] next_count;
  logic next_done;

  always_comb
  begin
    next_count = count;
    next_done = done;
    if (ce)
    begin
      if (clear)
        next_count = '0;
      else if (tick && count != {W{1'b1}})
        next_count = count + 1'b1;
      next_done = (next_count >= W'(LIMIT));
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      count <= '0;
      done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done <= next_done;
    end
  end
endmodule : tick_timer

/* File: core/ensemble_sequencer.sv */
`timescale 1ns/10ps
module ensemble_sequencer
  import mode_seq_pkg::*;
#(
  parameter int unsigned CNT_W = PING_CNT_W
)(
  input wire logic clock, // system clock
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic enable, // ping mode running
  input wire logic [CNT_W-1:0] ping_count, // pings per ensemble, 0 acts as 1
  input wire logic to_card, // 1 card recorder, 0 serial port
  input wire logic ping_done, // transmit finished
  input wire logic echo_done, // echo reception finished
  input wire logic selftest_done, // self-test processed
  input wire logic sensor_done, // sensors read
  input wire logic interval_end, // ensemble interval over
  output logic ping_tx, // transmit request
  output logic selftest_inject, // inject test signal
  output logic sensor_read, // sensor read request
  output logic accumulate, // add ping into average
  output logic ens_serial, // send ensemble to serial
  output logic ens_card, // write ensemble to card
  output logic ens_done // ensemble finished
);
  seq_state_t seq, next_seq;
  logic [CNT_W-1:0] n, next_n;
  logic next_acc, next_ser, next_card, next_done;

  always_comb
  begin
    next_seq = seq;
    next_n = n;
    next_acc = accumulate;
    next_ser = ens_serial;
    next_card = ens_card;
    next_done = ens_done;
    if (ce)
    begin
      next_acc = 1'b0;
      next_ser = 1'b0;
      next_card = 1'b0;
      next_done = 1'b0;
      if (!enable)
        next_seq = Q_IDLE;
      else
        case (seq)
          Q_IDLE:
          begin
            next_n = '0;
            next_seq = Q_TX;
          end
          Q_TX: if (ping_done) next_seq = Q_RX;
          Q_RX: if (echo_done) next_seq = Q_TEST;
          Q_TEST: if (selftest_done) next_seq = Q_SENSE;
          Q_SENSE:
            if (sensor_done)
            begin
              next_acc = 1'b1;
              next_n = n + 1'b1;
              next_seq = (next_n >= ping_count) ? Q_HOLD : Q_TX;
            end
          Q_HOLD:
            if (interval_end)
            begin
              next_ser = !to_card;
              next_card = to_card;
              next_done = 1'b1;
              next_seq = Q_IDLE;
            end
          default: next_seq = Q_IDLE;
        endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      seq <= Q_IDLE;
      n <= '0;
      ping_tx <= 1'b0;
      selftest_inject <= 1'b0;
      sensor_read <= 1'b0;
      accumulate <= 1'b0;
      ens_serial <= 1'b0;
      ens_card <= 1'b0;
      ens_done <= 1'b0;
    end
    else
    begin
      seq <= next_seq;
      n <= next_n;
      ping_tx <= (next_seq == Q_TX);
      selftest_inject <= (next_seq == Q_TEST);
      sensor_read <= (next_seq == Q_SENSE);
      accumulate <= next_acc;
      ens_serial <= next_ser;
      ens_card <= next_card;
      ens_done <= next_done;
    end
  end

  a_selftest_follows: assert property (@(posedge clock) disable iff (!rst_n)
    ce && enable && seq == Q_RX && echo_done |=> selftest_inject && !ping_tx)
    else $error("self-test not injected after echo");
  a_ens_routed: assert property (@(posedge clock) disable iff (!rst_n)
    $past(ce) && (ens_serial || ens_card)
    |-> ens_done && $past(seq == Q_HOLD) && (ens_card == to_card))
    else $error("ensemble output outside interval end");
endmodule : ensemble_sequencer

/* File: core/instrument_mode_sleep_sequencer.sv */
`timescale 1ns/10ps
module instrument_mode_sleep_sequencer
  import mode_seq_pkg::*;
#(
  parameter int unsigned SLEEP_TICKS = SLEEP_TICKS_DEF,
  parameter int unsigned CNT_W = PING_CNT_W
)(
  input wire logic clock, // 100 MHz
  input wire logic rst_n, // sync reset, active low
  input wire logic ce, // clock enable, freezes all
  input wire logic tick, // slow timekeeping tick pulse
  input wire logic serial_break, // break seen on serial
  input wire logic cmd_valid, // any valid command received
  input wire logic cmd_start, // start-collection command
  input wire logic first_ping_time_cmd, // first-ping time command
  input wire logic reset_switch, // hardware reset switch
  input wire logic unknown_state_wakeup, // unknown_state_wakeup / power restore
  input wire logic alarm_armed, // next-ping alarm set
  input wire logic alarm_fire, // next-ping alarm reached
  input wire logic tf_valid, // first-ping time not passed
  input wire logic tf_reached, // first-ping time arrived
  input wire logic [CNT_W-1:0] ping_count, // pings per ensemble
  input wire logic to_card, // ensemble to card recorder
  input wire logic ping_done, // transmit finished
  input wire logic echo_done, // echo reception finished
  input wire logic selftest_done, // self-test processed
  input wire logic sensor_done, // sensors read
  input wire logic interval_end, // ensemble interval over
  output logic awake, // powered up, not sleeping
  output logic cmd_prompt, // command prompt shown
  output logic self_deploy_warn, // self-deploy warning shown
  output logic deploy_active, // ping mode stored
  output logic recharging, // ram capacitor recharge
  output logic new_deployment, // new deployment started
  output logic [1:0] wake_source, // last wakeup source
  output logic wake_strobe, // wakeup just happened
  output logic ping_tx, // transmit request
  output logic selftest_inject, // inject test signal
  output logic sensor_read, // sensor read request
  output logic accumulate, // add ping into average
  output logic ens_serial, // ensemble to serial
  output logic ens_card, // ensemble to card
  output logic ens_done // ensemble finished
);
  mode_state_t state, next_state;
  logic next_deploy, tf_pending, next_tf_pend, tf_after_break, next_tf_brk;
  logic [1:0] next_src;
  logic next_stb, next_newdep, next_warn;
  logic in_prompt, sleeping, quiet;
  logic idle_clear, idle_done, sleep_done, chg_done;
  logic [TMR_W-1:0] idle_count, sleep_count;

  assign in_prompt = (state == S_PROMPT_CMD) || (state == S_PROMPT_PING);
  assign sleeping = (state == S_SLEEP) || (state == S_WAIT_TF) || (state == S_WAIT_ALARM);
  assign quiet = !unknown_state_wakeup && !reset_switch && !serial_break;
  // any command or break restarts the idle interval
  assign idle_clear = !in_prompt || serial_break || cmd_valid || cmd_start
                      || first_ping_time_cmd;

  tick_timer #(.W(TMR_W), .LIMIT(CMD_IDLE_TICKS)) idle_tmr (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .clear(idle_clear),
    .tick(tick),
    .count(idle_count),
    .done(idle_done)
  );

  // long sleep counter, cleared on wake
  tick_timer #(.W(TMR_W), .LIMIT(SLEEP_TICKS)) sleep_tmr (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .clear(!sleeping),
    .tick(tick),
    .count(sleep_count),
    .done(sleep_done)
  );

  tick_timer #(.W(TMR_W), .LIMIT(RECHARGE_TICKS)) chg_tmr (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .clear(state != S_RECHARGE),
    .tick(tick),
    .count(),
    .done(chg_done)
  );

  ensemble_sequencer #(.CNT_W(CNT_W)) seq_u (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .enable((state == S_PINGING) && !next_newdep),
    .ping_count(ping_count),
    .to_card(to_card),
    .ping_done(ping_done),
    .echo_done(echo_done),
    .selftest_done(selftest_done),
    .sensor_done(sensor_done),
    .interval_end(interval_end),
    .ping_tx(ping_tx),
    .selftest_inject(selftest_inject),
    .sensor_read(sensor_read),
    .accumulate(accumulate),
    .ens_serial(ens_serial),
    .ens_card(ens_card),
    .ens_done(ens_done)
  );

  // priority: unknown_state_wakeup, reset switch, break, then per-state events
  always_comb
  begin
    next_state = state;
    next_deploy = deploy_active;
    next_tf_pend = tf_pending;
    next_tf_brk = tf_after_break;
    next_src = wake_source;
    next_stb = wake_strobe;
    next_newdep = new_deployment;
    next_warn = self_deploy_warn;
    if (ce)
    begin
      next_stb = 1'b0;
      next_newdep = 1'b0;
      if (unknown_state_wakeup)
      begin
        next_src = WAKE_WDOG;
        next_stb = 1'b1;
        if (!deploy_active)
          next_state = S_PROMPT_CMD;
        else
        begin
          next_newdep = 1'b1;
          next_state = (tf_after_break && tf_valid) ? S_WAIT_TF : S_PINGING;
        end
      end
      else if (reset_switch)
      begin
        if (!deploy_active)
          next_state = S_SLEEP;
        else if (alarm_armed)
          next_state = S_WAIT_ALARM;
        else
        begin
          next_newdep = 1'b1;
          next_state = tf_after_break ? S_WAIT_TF : S_PINGING;
        end
      end
      else if (serial_break)
      begin
        next_src = WAKE_BREAK;
        next_stb = 1'b1;
        next_tf_brk = 1'b0;
        next_state = deploy_active ? S_PROMPT_PING : S_PROMPT_CMD;
      end
      else
        case (state)
          S_PROMPT_CMD, S_PROMPT_PING:
          begin
            if (first_ping_time_cmd)
            begin
              next_tf_pend = 1'b1;
              next_tf_brk = 1'b1;
            end
            if (cmd_start)
            begin
              // start, or sleep until first ping
              next_deploy = 1'b1;
              next_src = WAKE_START;
              next_stb = 1'b1;
              next_state = tf_pending ? S_WAIT_TF : S_PINGING;
            end
            // valid command returns to command mode
            else if (state == S_PROMPT_PING && cmd_valid)
            begin
              next_deploy = 1'b0;
              next_state = S_PROMPT_CMD;
            end
            else if (state == S_PROMPT_CMD && idle_done && !cmd_valid)
              next_state = S_SLEEP;
            else if (state == S_PROMPT_PING && !cmd_valid && !first_ping_time_cmd
                     && idle_count >= TMR_W'(RESUME_TICKS))
              next_state = S_PINGING;
          end
          S_SLEEP, S_WAIT_TF, S_WAIT_ALARM:
            if (state == S_WAIT_TF && tf_reached)
            begin
              next_tf_pend = 1'b0;
              next_state = S_PINGING;
            end
            else if (state == S_WAIT_ALARM && alarm_fire)
              next_state = S_PINGING;
            else if (sleep_done)
            begin
              next_src = WAKE_TIMER;
              next_stb = 1'b1;
              next_state = S_RECHARGE;
            end
          S_RECHARGE:
            if (chg_done)
            begin
              // back to sleep in command mode
              if (!deploy_active)
                next_state = S_SLEEP;
              else if (alarm_armed)
                next_state = S_WAIT_ALARM;
              else if (tf_pending && tf_valid)
                next_state = S_WAIT_TF;
              else
                next_state = S_PINGING;
            end
          S_PINGING:
            // battery saver between ensembles when the next ping is alarmed
            if (ens_done && alarm_armed)
              next_state = S_WAIT_ALARM;
          default: next_state = S_SLEEP;
        endcase
      next_warn = (state == S_PROMPT_PING) && (next_state == S_PROMPT_PING)
                  && !idle_clear && (idle_count >= TMR_W'(WARN_TICKS));
    end
  end

  // deployment flag kept across sleep and unknown_state_wakeup
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state <= S_SLEEP;
      deploy_active <= 1'b0;
      tf_pending <= 1'b0;
      tf_after_break <= 1'b0;
      wake_source <= WAKE_WDOG;
      wake_strobe <= 1'b0;
      new_deployment <= 1'b0;
      self_deploy_warn <= 1'b0;
      awake <= 1'b0;
      cmd_prompt <= 1'b0;
      recharging <= 1'b0;
    end
    else
    begin
      state <= next_state;
      deploy_active <= next_deploy;
      tf_pending <= next_tf_pend;
      tf_after_break <= next_tf_brk;
      wake_source <= next_src;
      wake_strobe <= next_stb;
      new_deployment <= next_newdep;
      self_deploy_warn <= next_warn;
      awake <= !((next_state == S_SLEEP) || (next_state == S_WAIT_TF)
                 || (next_state == S_WAIT_ALARM));
      cmd_prompt <= (next_state == S_PROMPT_CMD) || (next_state == S_PROMPT_PING);
      recharging <= (next_state == S_RECHARGE);
    end
  end

  a_idle_to_sleep: assert property (@(posedge clock) disable iff (!rst_n)
    ce && quiet && state == S_PROMPT_CMD && idle_done && !cmd_valid && !cmd_start
    |=> state == S_SLEEP && !awake && !cmd_prompt)
    else $error("command mode idle timeout missed");
  a_break_prompt: assert property (@(posedge clock) disable iff (!rst_n)
    ce && serial_break && !unknown_state_wakeup && !reset_switch && !deploy_active
    |=> state == S_PROMPT_CMD && cmd_prompt && wake_strobe && wake_source == WAKE_BREAK)
    else $error("break did not reach command prompt");
  a_reset_sleeps: assert property (@(posedge clock) disable iff (!rst_n)
    ce && reset_switch && !unknown_state_wakeup && !deploy_active |=> state == S_SLEEP)
    else $error("reset switch did not sleep");
  a_start_pings: assert property (@(posedge clock) disable iff (!rst_n)
    ce && quiet && in_prompt && cmd_start && !tf_pending
    |=> state == S_PINGING && deploy_active && wake_source == WAKE_START)
    else $error("start command did not begin pinging");
  a_first_ping_wait: assert property (@(posedge clock) disable iff (!rst_n)
    ce && quiet && in_prompt && cmd_start && tf_pending |=> state == S_WAIT_TF && !awake)
    else $error("pending first-ping time not honoured");
  a_cold_prompt: assert property (@(posedge clock) disable iff (!rst_n)
    ce && unknown_state_wakeup && !deploy_active
    |=> cmd_prompt && wake_source == WAKE_WDOG && !new_deployment)
    else $error("unknown_state_wakeup did not prompt");
  a_recharge_back: assert property (@(posedge clock) disable iff (!rst_n)
    ce && quiet && state == S_RECHARGE && chg_done && !deploy_active |=> state == S_SLEEP)
    else $error("recharge did not return to sleep");
  a_break_keeps_mode: assert property (@(posedge clock) disable iff (!rst_n)
    ce && serial_break && !unknown_state_wakeup && !reset_switch && deploy_active
    |=> state == S_PROMPT_PING && deploy_active && cmd_prompt)
    else $error("break in ping mode lost the mode");
  a_warn_timing: assert property (@(posedge clock) disable iff (!rst_n)
    self_deploy_warn |-> state == S_PROMPT_PING && idle_count >= TMR_W'(WARN_TICKS))
    else $error("self-deploy warning out of place");
  a_prompt_resume: assert property (@(posedge clock) disable iff (!rst_n)
    ce && quiet && state == S_PROMPT_PING && !cmd_valid && !cmd_start
    && !first_ping_time_cmd && idle_count >= TMR_W'(RESUME_TICKS) |=> state == S_PINGING)
    else $error("prompt did not resume pinging");
  a_reset_alarm: assert property (@(posedge clock) disable iff (!rst_n)
    ce && reset_switch && !unknown_state_wakeup && deploy_active && alarm_armed
    |=> state == S_WAIT_ALARM && !awake)
    else $error("reset with alarm did not sleep");
  a_reset_redeploy: assert property (@(posedge clock) disable iff (!rst_n)
    ce && reset_switch && !unknown_state_wakeup && deploy_active && !alarm_armed
    |=> new_deployment && state == (tf_after_break ? S_WAIT_TF : S_PINGING))
    else $error("reset did not start new deployment");
  a_cold_redeploy: assert property (@(posedge clock) disable iff (!rst_n)
    ce && unknown_state_wakeup && deploy_active && !(tf_after_break && tf_valid)
    |=> new_deployment && state == S_PINGING ##1 (ping_tx || !$past(ce)))
    else $error("unknown_state_wakeup in ping mode did not ping");
  a_recharge_alarm: assert property (@(posedge clock) disable iff (!rst_n)
    ce && quiet && state == S_RECHARGE && chg_done && deploy_active && alarm_armed
    |=> state == S_WAIT_ALARM)
    else $error("recharge ignored armed alarm");
  a_sleep_cleared: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !sleeping |=> sleep_count == '0)
    else $error("sleep interval not restarted");
  a_deploy_persists: assert property (@(posedge clock) disable iff (!rst_n)
    !cmd_start && !cmd_valid |=> $stable(deploy_active))
    else $error("deployment flag changed without command");
endmodule : instrument_mode_sleep_sequencer

/* File: tb/host_model.sv */
`timescale 1ns/10ps
module host_model
(
  input wire logic clock, // system clock
  output logic serial_break, // break pulse
  output logic cmd_valid, // valid command pulse
  output logic cmd_start, // start-collection pulse
  output logic first_ping_time_cmd // first-ping time pulse
);
  initial
  begin
    {serial_break, cmd_valid, cmd_start, first_ping_time_cmd} = 4'h0;
  end

  task send(input logic [3:0] v);
    @(posedge clock);
    #1;
    {serial_break, cmd_valid, cmd_start, first_ping_time_cmd} = v;
    @(posedge clock);
    #1;
    {serial_break, cmd_valid, cmd_start, first_ping_time_cmd} = 4'h0;
  endtask : send
endmodule : host_model

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import mode_seq_pkg::*;
  logic clock, rst_n, tick, reset_switch, unknown_state_wakeup, alarm_armed, alarm_fire;
  logic tf_reached, interval_end, ping_done, echo_done, selftest_done, sensor_done;
  logic serial_break, cmd_valid, cmd_start, first_ping_time_cmd;
  logic awake, cmd_prompt, self_deploy_warn, deploy_active, recharging, new_deployment;
  logic wake_strobe, ping_tx, selftest_inject, sensor_read, accumulate;
  logic ens_serial, ens_card, ens_done;
  logic [1:0] wake_source;
  int miscompares = 0;
  int checks_done = 0;
  logic ce, tf_valid, to_card;
  logic [7:0] ping_count;
  int n_acc, n_test, n_card, n_new, n_ser, n_stb, tcnt, base, d;

  // short sleep span keeps the recharge case inside the run
  instrument_mode_sleep_sequencer #(.SLEEP_TICKS(20), .CNT_W(8)) dut_u (
    .clock, .rst_n, .ce, .tick, .serial_break, .cmd_valid, .cmd_start,
    .first_ping_time_cmd, .reset_switch, .unknown_state_wakeup, .alarm_armed, .alarm_fire,
    .tf_valid, .tf_reached, .ping_count, .to_card, .ping_done, .echo_done,
    .selftest_done, .sensor_done, .interval_end, .awake, .cmd_prompt, .self_deploy_warn,
    .deploy_active, .recharging, .new_deployment, .wake_source, .wake_strobe, .ping_tx,
    .selftest_inject, .sensor_read, .accumulate, .ens_serial, .ens_card, .ens_done);
  host_model host_u (.clock, .serial_break, .cmd_valid, .cmd_start, .first_ping_time_cmd);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // front end answers each step one cycle late; tick every 4 clocks
  always @(posedge clock)
  begin
    n_acc = n_acc + accumulate;
    n_test = n_test + selftest_inject;
    n_card = n_card + (ens_card & ens_done);
    n_ser = n_ser + (ens_serial & ens_done);
    n_new = n_new + new_deployment;
    n_stb = n_stb + wake_strobe;
    #1;
    tcnt = (tcnt + 1) % 4;
    tick = (tcnt == 0);
    echo_done = ping_done;
    ping_done = ping_tx & ~ping_done & ~echo_done;
    selftest_done = selftest_inject & ~selftest_done;
    sensor_done = sensor_read & ~sensor_done;
  end

  task chk(input logic [1:0] seen, input logic [1:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: saw %b, expected %b", $time, seen, exp);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task ev(input logic [4:0] v);
    step(1);
    {reset_switch, unknown_state_wakeup, tf_reached, interval_end, alarm_fire} = v;
    step(1);
    {reset_switch, unknown_state_wakeup, tf_reached, interval_end, alarm_fire} = 5'h0;
  endtask : ev

  task do_reset;
    rst_n = 1'b0;
    step(2);
    rst_n = 1'b1;
  endtask : do_reset

  task t_cmd_idle;
    host_u.send(4'h8);
    step(2);
    chk(cmd_prompt, 1'b1);
    chk(wake_source, WAKE_BREAK);
    chk(n_stb[1:0], 2'h1);
    step(800);
    host_u.send(4'h4);
    step(800);
    chk(awake, 1'b1);
    step(440);
    chk(awake, 1'b0);
    step(48);
    chk({recharging, awake}, 2'h3);
    chk(wake_source, WAKE_TIMER);
    step(32);
    chk({recharging, awake}, 2'h0);
  endtask : t_cmd_idle

  task t_switch_cmd;
    host_u.send(4'h8);
    ev(5'h10);
    step(2);
    chk({awake, cmd_prompt}, 2'h0);
    ev(5'h08);
    step(2);
    chk({cmd_prompt, deploy_active}, 2'h2);
    chk(wake_source, WAKE_WDOG);
    // frozen core must ignore the switch
    ce = 1'b0;
    ev(5'h10);
    step(2);
    ce = 1'b1;
    chk({cmd_prompt, awake}, 2'h3);
  endtask : t_switch_cmd

  task t_deploy;
    host_u.send(4'h6);
    step(2);
    chk({deploy_active, cmd_prompt}, 2'h2);
    step(40);
    chk(n_acc[1:0], 2'h2);
    chk(n_test[1:0], 2'h2);
    ev(5'h02);
    step(2);
    chk(n_card[1:0], 2'h1);
    host_u.send(4'h8);
    step(2);
    chk({cmd_prompt, deploy_active}, 2'h3);
    step(968);
    chk(self_deploy_warn, 1'b1);
    step(240);
    chk({cmd_prompt, awake}, 2'h1);
    base = n_new;
    ev(5'h08);
    step(2);
    d = n_new - base;
    chk(d[1:0], 2'h1);
    chk({awake, cmd_prompt}, 2'h2);
    chk(deploy_active, 1'b1);
    alarm_armed = 1'b1;
    ev(5'h10);
    step(2);
    chk(awake, 1'b0);
    ev(5'h01);
    step(2);
    chk(awake, 1'b1);
    alarm_armed = 1'b0;
    {ping_count, to_card} = {8'h03, 1'b0};
    base = n_new;
    ev(5'h10);
    step(2);
    d = n_new - base;
    chk(d[1:0], 2'h1);
    base = n_acc;
    step(20);
    d = n_acc - base;
    chk(d[1:0], 2'h3);
    base = n_card;
    ev(5'h02);
    step(2);
    chk(n_ser[1:0], 2'h1);
    d = n_card - base;
    chk(d[1:0], 2'h0);
  endtask : t_deploy

  task t_first_ping;
    do_reset;
    host_u.send(4'h8);
    host_u.send(4'h5);
    host_u.send(4'h6);
    step(2);
    chk({awake, deploy_active}, 2'h1);
    ev(5'h04);
    step(2);
    chk(awake, 1'b1);
  endtask : t_first_ping

  // first-ping time set after the last break, then reset and recharge in ping mode
  task t_ping_tf;
    tf_valid = 1'b0;
    ev(5'h08);
    step(2);
    chk({awake, cmd_prompt}, 2'h2);
    tf_valid = 1'b1;
    ev(5'h08);
    step(2);
    chk(awake, 1'b0);
    ev(5'h04);
    step(2);
    chk(awake, 1'b1);
    ev(5'h10);
    step(2);
    chk(awake, 1'b0);
    ev(5'h01);
    step(2);
    chk(awake, 1'b0);
    alarm_armed = 1'b1;
    step(82);
    chk({recharging, awake}, 2'h3);
    step(22);
    chk({recharging, awake}, 2'h0);
    ev(5'h01);
    step(2);
    chk(awake, 1'b1);
  endtask : t_ping_tf

  task report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  initial
  begin
    {reset_switch, unknown_state_wakeup, tf_reached, interval_end, alarm_fire} = 5'h0;
    {tick, alarm_armed, ping_done, echo_done, selftest_done, sensor_done} = 6'h0;
    {ce, tf_valid, to_card, ping_count} = {1'b1, 1'b1, 1'b1, 8'h02};
    do_reset;
    t_cmd_idle;
    t_switch_cmd;
    t_deploy;
    t_first_ping;
    t_ping_tf;
    report_and_stop;
  end

  // about five times the expected run length
  initial
  begin
    #200000;
    miscompares++;
    report_and_stop;
  end
endmodule : testbench
